// ==== src/power_and_attenuator_control.sv ====
// power-down, standby and attenuator control register bank
`timescale 1ns/10ps
module power_and_attenuator_control #(
  parameter int SAMPLE_W = 16
) (
  // clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // register port
  input  wire logic [12:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_we,
  input  wire logic                reg_re,
  output logic      [7:0]          reg_rdata,
  output logic                     reg_rvalid,
  // standby request from the standby control register
  input  wire logic                standby_request,
  // gain-control pins, asynchronous
  input  wire logic                gain_pin_one,
  input  wire logic                gain_pin_two,
  input  wire logic                gain_pin_three,
  input  wire logic                gain_pin_four,
  // sample path
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output logic      [SAMPLE_W-1:0] sample_out,
  // power-down controls
  output logic                     standby_active,
  output logic                     pd_neg_supply_gen,
  output logic                     pd_main_clock_pll,
  output logic                     pd_link_pll,
  output logic                     pd_link_transmitters,
  output logic                     pd_link_framer,
  output logic                     pd_digital_datapath,
  output logic                     pd_digital_clocks,
  // attenuator
  output logic      [4:0]          atten_value,
  output logic                     atten_disable
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] output_format_ctrl_q;    // format select plus spare bits
  logic [7:0] standby_block_select_q;  // blocks to drop in standby
  logic [7:0] immediate_power_down_q;  // unconditional power-down
  logic [7:0] standby_pin_ctrl_q;      // pin enable and pin choice
  logic [7:0] attenuator_mode_ctrl_q;  // mode bit plus spare bits
  logic [7:0] atten_value_pin_low_q;   // value for pin two low
  logic [7:0] atten_value_pin_high_q;  // value for pin two high
  logic [7:0] step_mode_start_value_q; // step-mode start value
  logic [1:0] status_spare_q;          // spare writable status bits

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [3:0] pins_raw;       // pins gathered, one to four
  logic [3:0] pins_s;         // synchronised pins
  logic [1:0] step_pins_q;    // last value of pins one and two
  logic       mode_q;         // last attenuator mode, for load
  logic       step_mode;      // attenuator mode one
  logic       step_down;      // rising edge on pin one
  logic       step_up;        // rising edge on pin two
  logic       step_load;      // restart step counter
  logic       start_wr;       // start value written this cycle
  logic [7:0] start_src;      // value the counter restarts from
  logic [4:0] step_value;     // step-mode attenuation

  assign pins_raw = {gain_pin_four, gain_pin_three, gain_pin_two, gain_pin_one};

  pin_sync #(
    .WIDTH     (pwr_atten_pkg::GAIN_PINS)
  ) u_pin_sync (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .pins      (pins_raw),
    .pins_sync (pins_s)
  );

  // remember step pins and mode so edges can be found
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_pins_q <= 2'h0;
      mode_q      <= 1'b0;
    end else if (ce) begin
      step_pins_q <= pins_s[1:0];
      mode_q      <= step_mode;
    end
  end

  assign step_mode = attenuator_mode_ctrl_q[pwr_atten_pkg::ATTENUATOR_MODE_CTRL_BIT];
  // each rising edge is one step command from the gain controller
  assign step_down = pins_s[0] & ~step_pins_q[0];
  assign step_up   = pins_s[1] & ~step_pins_q[1];
  // load on entry to mode one, or on a new start value in mode one
  assign start_wr  = reg_we & (reg_addr == pwr_atten_pkg::ADDR_STEP_START);
  assign step_load = step_mode & (~mode_q | start_wr);
  // the start register only holds the new value after this edge, so a
  // load caused by the write itself must take the write data directly;
  // otherwise the counter would restart from the stale start value
  assign start_src = start_wr ? reg_wdata : step_mode_start_value_q;

  atten_stepper u_stepper (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .load        (step_load),
    .start_value (start_src),
    .step_en     (step_mode),
    .step_down   (step_down),
    .step_up     (step_up),
    .value_q     (step_value)
  );

  // ----------------------------------------------------------------
  // register writes; every bit stored, spare ones included, except status, which keeps only bits 6:5
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_format_ctrl_q    <= pwr_atten_pkg::RST_OUTPUT_FORMAT;
      standby_block_select_q  <= pwr_atten_pkg::RST_STBY_SELECT;
      immediate_power_down_q  <= pwr_atten_pkg::RST_NOW_OFF;
      standby_pin_ctrl_q      <= pwr_atten_pkg::RST_STBY_PIN;
      attenuator_mode_ctrl_q  <= pwr_atten_pkg::RST_ATTENUATOR_MODE_CTRL;
      atten_value_pin_low_q   <= pwr_atten_pkg::RST_ATTEN_VALUE;
      atten_value_pin_high_q  <= pwr_atten_pkg::RST_ATTEN_VALUE;
      step_mode_start_value_q <= pwr_atten_pkg::RST_STEP_START;
      status_spare_q          <= pwr_atten_pkg::RST_STATUS_SPARE;
    end else if (ce && reg_we) begin
      case (reg_addr)
        pwr_atten_pkg::ADDR_OUTPUT_FORMAT: output_format_ctrl_q    <= reg_wdata;
        pwr_atten_pkg::ADDR_STBY_SELECT:   standby_block_select_q  <= reg_wdata;
        pwr_atten_pkg::ADDR_NOW_OFF:       immediate_power_down_q  <= reg_wdata;
        pwr_atten_pkg::ADDR_STBY_PIN:      standby_pin_ctrl_q      <= reg_wdata;
        pwr_atten_pkg::ADDR_ATTENUATOR_MODE_CTRL:    attenuator_mode_ctrl_q  <= reg_wdata;
        pwr_atten_pkg::ADDR_ATTEN_LOW:     atten_value_pin_low_q   <= reg_wdata;
        pwr_atten_pkg::ADDR_ATTEN_HIGH:    atten_value_pin_high_q  <= reg_wdata;
        pwr_atten_pkg::ADDR_STEP_START:    step_mode_start_value_q <= reg_wdata;
        pwr_atten_pkg::ADDR_ATTEN_STATUS:  status_spare_q          <= reg_wdata[6:5];
        default: ;  // unmapped writes are dropped
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads; one cycle latency, unmapped reads give zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_re;
      if (reg_re) begin
        case (reg_addr)
          pwr_atten_pkg::ADDR_OUTPUT_FORMAT: reg_rdata <= output_format_ctrl_q;
          pwr_atten_pkg::ADDR_STBY_SELECT:   reg_rdata <= standby_block_select_q;
          pwr_atten_pkg::ADDR_NOW_OFF:       reg_rdata <= immediate_power_down_q;
          pwr_atten_pkg::ADDR_STBY_PIN:      reg_rdata <= standby_pin_ctrl_q;
          pwr_atten_pkg::ADDR_ATTENUATOR_MODE_CTRL:    reg_rdata <= attenuator_mode_ctrl_q;
          pwr_atten_pkg::ADDR_ATTEN_LOW:     reg_rdata <= atten_value_pin_low_q;
          pwr_atten_pkg::ADDR_ATTEN_HIGH:    reg_rdata <= atten_value_pin_high_q;
          pwr_atten_pkg::ADDR_STEP_START:    reg_rdata <= step_mode_start_value_q;
          // pin two state, spare bits, step-mode value
          pwr_atten_pkg::ADDR_ATTEN_STATUS:
            reg_rdata <= {pins_s[1], status_spare_q, step_value};
          default:                           reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // standby decision
  // ----------------------------------------------------------------
  logic standby_d;  // standby seen this cycle
  logic pin_level;  // chosen gain pin

  assign pin_level = pins_s[standby_pin_ctrl_q[1:0]];
  // pins count only when enabled; then it is a plain OR
  assign standby_d = standby_request |
                     (standby_pin_ctrl_q[pwr_atten_pkg::PIN_ENABLE_BIT] & pin_level);

  // ----------------------------------------------------------------
  // power-down outputs; each select bit gates only its own block
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_active       <= 1'b0;
      pd_neg_supply_gen    <= 1'b0;
      pd_main_clock_pll    <= 1'b0;
      pd_link_pll          <= 1'b0;
      pd_link_transmitters <= 1'b0;
      pd_link_framer       <= 1'b0;
      pd_digital_datapath  <= 1'b0;
      pd_digital_clocks    <= 1'b0;
    end else if (ce) begin
      standby_active       <= standby_d;
      pd_neg_supply_gen    <= standby_d &
                              standby_block_select_q[pwr_atten_pkg::STBY_NEG_SUPPLY];
      pd_main_clock_pll    <= standby_d &
                              standby_block_select_q[pwr_atten_pkg::STBY_MAIN_PLL];
      pd_link_pll          <= standby_d &
                              standby_block_select_q[pwr_atten_pkg::STBY_LINK_PLL];
      pd_link_transmitters <= standby_d &
                              standby_block_select_q[pwr_atten_pkg::STBY_LINK_TX];
      // immediate bits act with or without standby
      pd_link_framer       <= (standby_d & standby_block_select_q[pwr_atten_pkg::STBY_LINK_FRAMER]) |
                              immediate_power_down_q[pwr_atten_pkg::NOW_OFF_FRAMER];
      pd_digital_datapath  <= (standby_d & standby_block_select_q[pwr_atten_pkg::STBY_DIGITAL_DATAPATH]) |
                              immediate_power_down_q[pwr_atten_pkg::NOW_OFF_DATAPATH];
      pd_digital_clocks    <= (standby_d &
                               standby_block_select_q[pwr_atten_pkg::STBY_DIG_CLOCKS]) |
                              immediate_power_down_q[pwr_atten_pkg::NOW_OFF_CLOCKS];
    end
  end

  // ----------------------------------------------------------------
  // attenuation in use
  // ----------------------------------------------------------------
  logic [7:0] pin_value;     // mode zero choice
  logic [7:0] chosen_value;  // value before range check

  // high value only reachable in mode zero with pin two high
  assign pin_value    = pins_s[1] ? atten_value_pin_high_q : atten_value_pin_low_q;
  assign chosen_value = step_mode ? {3'h0, step_value} : pin_value;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      atten_value   <= pwr_atten_pkg::ATTEN_MIN;
      atten_disable <= 1'b0;
    end else if (ce) begin
      // anything above 27 switches the attenuator off
      if (chosen_value > {3'h0, pwr_atten_pkg::ATTEN_MAX}) begin
        atten_value   <= pwr_atten_pkg::ATTEN_OFF_CODE;
        atten_disable <= 1'b1;
      end else begin
        atten_value   <= chosen_value[4:0];
        atten_disable <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample format: flipping the sign bit gives offset binary
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_out <= '0;
    end else if (ce) begin
      sample_out <= sample_in ^
        {output_format_ctrl_q[pwr_atten_pkg::OFFSET_BIN_BIT], {(SAMPLE_W-1){1'b0}}};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_format;
    @(posedge clk) disable iff (rst)
      ce |=> sample_out[SAMPLE_W-1] == ($past(sample_in[SAMPLE_W-1]) ^
             $past(output_format_ctrl_q[pwr_atten_pkg::OFFSET_BIN_BIT]));
  endproperty
  a_format: assert property (p_format) else $error("sample sign bit wrong");

  property p_neg_supply;
    @(posedge clk) disable iff (rst)
      ce |=> pd_neg_supply_gen == ($past(standby_d) &&
             $past(standby_block_select_q[pwr_atten_pkg::STBY_NEG_SUPPLY]));
  endproperty
  a_neg_supply: assert property (p_neg_supply) else $error("supply gen power-down wrong");

  property p_main_pll;
    @(posedge clk) disable iff (rst)
      (ce && !standby_d) |=> !pd_main_clock_pll;
  endproperty
  a_main_pll: assert property (p_main_pll) else $error("pll off outside standby");

  property p_now_off;
    @(posedge clk) disable iff (rst)
      (ce && immediate_power_down_q[pwr_atten_pkg::NOW_OFF_FRAMER])
      |=> pd_link_framer;
  endproperty
  a_now_off: assert property (p_now_off) else $error("immediate framer power-down missed");

  property p_pin_ignored;
    @(posedge clk) disable iff (rst)
      (ce && !standby_pin_ctrl_q[pwr_atten_pkg::PIN_ENABLE_BIT])
      |=> standby_active == $past(standby_request);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("pin acted while disabled");

  property p_pin_select;
    @(posedge clk) disable iff (rst)
      (ce && standby_pin_ctrl_q[pwr_atten_pkg::PIN_ENABLE_BIT] &&
       pins_s[standby_pin_ctrl_q[1:0]]) |=> standby_active;
  endproperty
  a_pin_select: assert property (p_pin_select) else $error("selected pin missed");

  property p_mode0_value;
    @(posedge clk) disable iff (rst)
      (ce && !step_mode && pin_value <= 8'h1B) |=> atten_value == $past(pin_value[4:0]);
  endproperty
  a_mode0_value: assert property (p_mode0_value) else $error("mode zero value wrong");

  property p_disable;
    @(posedge clk) disable iff (rst)
      (ce && chosen_value > 8'h1B) |=> atten_disable ##0 atten_value == 5'h1F;
  endproperty
  a_disable: assert property (p_disable) else $error("out-of-range value not disabled");

  property p_reset_values;
    @(posedge clk)
      $fell(rst) |-> atten_value_pin_low_q == 8'h0C && atten_value_pin_high_q == 8'h0C &&
                     standby_block_select_q == 8'h02;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");
endmodule

// ==== src/pwr_atten_pkg.sv ====
// package: register map, field positions, reset values and limits
package pwr_atten_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 13;
  localparam logic [12:0] ADDR_OUTPUT_FORMAT = 13'h146;
  localparam logic [12:0] ADDR_STBY_SELECT   = 13'h150;
  localparam logic [12:0] ADDR_NOW_OFF       = 13'h151;
  localparam logic [12:0] ADDR_STBY_PIN      = 13'h152;
  localparam logic [12:0] ADDR_ATTENUATOR_MODE_CTRL    = 13'h180;
  localparam logic [12:0] ADDR_ATTEN_LOW     = 13'h181;
  localparam logic [12:0] ADDR_ATTEN_HIGH    = 13'h182;
  localparam logic [12:0] ADDR_STEP_START    = 13'h183;
  localparam logic [12:0] ADDR_ATTEN_STATUS  = 13'h184;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_OUTPUT_FORMAT  = 8'h00;
  localparam logic [7:0]  RST_STBY_SELECT    = 8'h02;
  localparam logic [7:0]  RST_NOW_OFF        = 8'h00;
  localparam logic [7:0]  RST_STBY_PIN       = 8'h00;
  localparam logic [7:0]  RST_ATTENUATOR_MODE_CTRL     = 8'h00;
  localparam logic [7:0]  RST_ATTEN_VALUE    = 8'h0C;
  localparam logic [7:0]  RST_STEP_START     = 8'h00;
  localparam logic [1:0]  RST_STATUS_SPARE   = 2'h0;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          OFFSET_BIN_BIT     = 0;
  localparam int          STBY_NEG_SUPPLY    = 6;
  localparam int          STBY_MAIN_PLL      = 5;
  localparam int          STBY_LINK_PLL      = 4;
  localparam int          STBY_LINK_TX       = 3;
  localparam int          STBY_LINK_FRAMER        = 2;
  localparam int          STBY_DIGITAL_DATAPATH      = 1;
  localparam int          STBY_DIG_CLOCKS    = 0;
  localparam int          NOW_OFF_FRAMER     = 2;
  localparam int          NOW_OFF_DATAPATH   = 1;
  localparam int          NOW_OFF_CLOCKS     = 0;
  localparam int          PIN_ENABLE_BIT     = 4;
  localparam int          ATTENUATOR_MODE_CTRL_BIT     = 0;
  localparam int          STATUS_PIN_BIT     = 7;
  // ----------------------------------------------------------------
  // attenuator limits and pin count
  // ----------------------------------------------------------------
  localparam logic [4:0]  ATTEN_MIN          = 5'h00;
  localparam logic [4:0]  ATTEN_MAX          = 5'h1B;
  localparam logic [4:0]  ATTEN_OFF_CODE     = 5'h1F;
  localparam int          GAIN_PINS          = 4;
  localparam int          SYNC_STAGES        = 2;
endpackage

// ==== src/pin_sync.sv ====
// two-stage synchroniser for asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_sync
);
  logic [WIDTH-1:0] meta_q;  // first stage, read only by second stage

  // ----------------------------------------------------------------
  // two flops in series; first stage feeds nothing else
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q    <= '0;
      pins_sync <= '0;
    end else if (ce) begin
      meta_q    <= pins;
      pins_sync <= meta_q;
    end
  end
endmodule

// ==== src/atten_stepper.sv ====
// step-mode attenuation counter: load, one-step up/down, saturating
`timescale 1ns/10ps
module atten_stepper (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       load,
  input  wire logic [7:0] start_value,
  input  wire logic       step_en,
  input  wire logic       step_down,
  input  wire logic       step_up,
  // current value
  output logic      [4:0] value_q
);
  // ----------------------------------------------------------------
  // counter; out-of-range start parks the attenuator disabled
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= pwr_atten_pkg::ATTEN_MIN;
    end else if (ce) begin
      if (load) begin
        value_q <= (start_value > 8'h1F) ? pwr_atten_pkg::ATTEN_OFF_CODE : start_value[4:0];
      end else if (step_en && (step_up != step_down)) begin
        // saturate, never wrap; a disabled code is not stepped
        if (step_up && value_q < pwr_atten_pkg::ATTEN_MAX) begin
          value_q <= value_q + 5'h01;
        end else if (step_down && value_q > pwr_atten_pkg::ATTEN_MIN &&
                     value_q <= pwr_atten_pkg::ATTEN_MAX) begin
          value_q <= value_q - 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_step_saturate;
    @(posedge clk) disable iff (rst)
      (ce && !load && step_en && step_up && !step_down && value_q == pwr_atten_pkg::ATTEN_MAX)
      |=> value_q == pwr_atten_pkg::ATTEN_MAX;
  endproperty
  a_step_saturate: assert property (p_step_saturate) else $error("step went past 27");

  property p_step_floor;
    @(posedge clk) disable iff (rst)
      (ce && !load && step_en && step_down && !step_up && value_q == pwr_atten_pkg::ATTEN_MIN)
      |=> value_q == pwr_atten_pkg::ATTEN_MIN;
  endproperty
  a_step_floor: assert property (p_step_floor) else $error("step wrapped below 0");
endmodule

// ==== testbench/gain_ctrl_model.sv ====
// gain-control partner: drives the four gain pins from bench commands
`timescale 1ns/10ps
module gain_ctrl_model (
  // clock and bench command
  input  wire logic       clk,
  input  wire logic [3:0] want,
  // gain pins
  output logic      [3:0] pins
);
  // pins move just after the edge, like an outside controller in step
  initial pins = 4'h0;
  always @(posedge clk) begin
    pins <= want;
  end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the power and attenuator register bank
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, rst, ce, reg_we, reg_re, reg_rvalid, standby_request;
  logic        standby_active, atten_disable;
  logic [12:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] sample_in, sample_out;
  logic [3:0]  want, pins;
  logic [6:0]  pd;
  logic [4:0]  atten_value;
  int          mismatches, compares, i;
  gain_ctrl_model far_end (.clk(clk), .want(want), .pins(pins));
  power_and_attenuator_control dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .standby_request(standby_request), .gain_pin_one(pins[0]),
    .gain_pin_two(pins[1]), .gain_pin_three(pins[2]), .gain_pin_four(pins[3]),
    .sample_in(sample_in), .sample_out(sample_out), .standby_active(standby_active),
    .pd_neg_supply_gen(pd[6]), .pd_main_clock_pll(pd[5]), .pd_link_pll(pd[4]),
    .pd_link_transmitters(pd[3]), .pd_link_framer(pd[2]), .pd_digital_datapath(pd[1]),
    .pd_digital_clocks(pd[0]), .atten_value(atten_value), .atten_disable(atten_disable));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict and end of run, also reached when a wait runs out
  task automatic summarize;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // model flop, two sync flops and the output flop take four edges; one spare
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask
  // strobe drops for a full cycle so back-to-back calls never clash
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    int n;
    reg_addr = a;
    reg_re = 1'b1;
    @(negedge clk);
    reg_re = 1'b0;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk);
    if (n == 4) begin
      mismatches++;
      summarize();
    end else cmp("rdata", {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  // one step pulse, long enough high and low for the synchroniser
  task automatic pulse(input int p);
    want[p] = 1'b1;
    repeat (3) @(negedge clk);
    want[p] = 1'b0;
    settle();
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, reg_we, reg_re, standby_request} = 5'b11000;
    {reg_addr, reg_wdata, want, mismatches, compares} = '0;
    sample_in = 16'h1234;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    rd(13'h146, 8'h00);
    rd(13'h150, 8'h02);
    rd(13'h181, 8'h0C);
    rd(13'h182, 8'h0C);
    rd(13'h1FF, 8'h00);
    cmp("atten", 16'h000C, {11'h000, atten_value});
    cmp("sample", 16'h1234, sample_out);
    wr(13'h146, 8'hFF);
    settle();
    cmp("sample", 16'h9234, sample_out);
    rd(13'h146, 8'hFF);
    // each select bit cuts only its own block while in standby
    standby_request = 1'b1;
    for (i = 0; i < 7; i++) begin
      wr(13'h150, 8'(8'h01 << i));
      settle();
      cmp("pd", {8'h00, 8'(8'h01 << i)}, {9'h000, pd});
    end
    wr(13'h150, 8'h80);
    settle();
    cmp("pd", 16'h0000, {9'h000, pd});
    standby_request = 1'b0;
    wr(13'h150, 8'h7F);
    wr(13'h151, 8'h07);
    settle();
    cmp("pd", 16'h0007, {9'h000, pd});
    wr(13'h151, 8'h00);
    wr(13'h152, 8'h03);
    want = 4'hF;
    settle();
    cmp("standby", 16'h0000, {15'h0000, standby_active});
    for (i = 0; i < 4; i++) begin
      wr(13'h152, 8'(8'h10 | i));
      want = 4'(4'h1 << i);
      settle();
      cmp("standby", 16'h0001, {15'h0000, standby_active});
      want = ~4'(4'h1 << i);
      settle();
      cmp("standby", 16'h0000, {15'h0000, standby_active});
    end
    want = 4'h0;
    standby_request = 1'b1;
    settle();
    cmp("standby", 16'h0001, {15'h0000, standby_active});
    standby_request = 1'b0;
    // pin two chooses between the two stored values
    wr(13'h181, 8'h05);
    wr(13'h182, 8'h1B);
    settle();
    cmp("atten", 16'h0005, {11'h000, atten_value});
    want = 4'h2;
    settle();
    cmp("atten", 16'h001B, {11'h000, atten_value});
    wr(13'h182, 8'h1C);
    settle();
    cmp("atten", 16'h003F, {10'h000, atten_disable, atten_value});
    // step mode loads the start value, then saturates at the top
    want = 4'h0;
    wr(13'h183, 8'h1A);
    wr(13'h180, 8'h01);
    wr(13'h182, 8'h03);
    settle();
    cmp("atten", 16'h001A, {11'h000, atten_value});
    pulse(1);
    pulse(1);
    cmp("atten", 16'h001B, {10'h000, atten_disable, atten_value});
    rd(13'h184, 8'h1B);
    pulse(0);
    cmp("atten", 16'h001A, {11'h000, atten_value});
    wr(13'h183, 8'h00);
    pulse(0);
    cmp("atten", 16'h0000, {11'h000, atten_value});
    summarize();
  end
endmodule
